// File: src/mem_bus_defs.svh
// constants for the core memory bus cycle interface
`ifndef MEM_BUS_DEFS_SVH
`define MEM_BUS_DEFS_SVH
`define CYC_INTERNAL   2'h0
`define CYC_COPROC     2'h1
`define CYC_NONSEQ     2'h2
`define CYC_SEQ        2'h3
`define WIDTH_BYTE     2'h0
`define WIDTH_HALF     2'h1
`define WIDTH_WORD     2'h2
`define PROT_USER_OP   2'h0
`define PROT_USER_DATA 2'h1
`define PROT_PRIV_OP   2'h2
`define PROT_PRIV_DATA 2'h3
`define INC_WORD       32'h0000_0004
`define INC_HALF       32'h0000_0002
`define ADDR_RESET     32'h0000_0000
`endif

// File: src/mem_bus_pkg.sv
// types for the core memory bus cycle interface
package mem_bus_pkg;
	typedef enum logic [1:0] {
		cyc_internal = 2'h0,
		cyc_coproc   = 2'h1,
		cyc_nonseq   = 2'h2,
		cyc_seq      = 2'h3
	} cycle_type_t;
	typedef enum logic [2:0] {
		req_idle    = 3'h0,
		req_single  = 3'h1,
		req_burst   = 3'h2,
		req_merged  = 3'h3,
		req_coproc  = 3'h4
	} req_kind_t;
endpackage

// File: src/mem_bus_if.sv
// interface joining the core bus end and the memory controller end
`timescale 1ns/1ps
interface mem_bus_if;
	logic [31:0] addr;
	logic        write;
	logic [1:0]  transfer_width;
	logic [1:0]  access_protection_code;
	logic [1:0]  bus_cycle_type;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        bus_cycle_stretch_enable;
	modport core (
		output addr, write, transfer_width, access_protection_code, bus_cycle_type, wdata,
		input  rdata, bus_cycle_stretch_enable
	);
	modport mem (
		input  addr, write, transfer_width, access_protection_code, bus_cycle_type, wdata,
		output rdata, bus_cycle_stretch_enable
	);
endinterface

// File: src/mem_ctrl_end.sv
// memory controller end: stretches cycles, commits only on n and s cycles
`timescale 1ns/1ps
`include "mem_bus_defs.svh"
module mem_ctrl_end #(
	parameter int WAIT_NONSEQ = 1
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	mem_bus_if.mem           bus,
	input  wire logic        mem_ready,
	input  wire logic [31:0] mem_rdata,
	output logic             mem_start,
	output logic             mem_write,
	output logic [31:0]      mem_addr,
	output logic [3:0]       mem_byte_en,
	output logic [31:0]      mem_wdata
);
	//////////////////////////////////////////////////////////////////////////////
	logic        pend;
	logic        pend_write;
	logic [7:0]  wait_cnt;
	logic        stretch;
	wire         cyc_commit = bus.bus_cycle_type[1];                            // [R9] [R12] [R22]
	wire         cyc_nonseq = bus.bus_cycle_type == `CYC_NONSEQ;
	wire         cyc_end    = stretch;                                          // [R15]
	wire         need_wait  = cyc_nonseq && (WAIT_NONSEQ != 0);                 // [R1] [R3] [R11]
	wire         wait_done  = wait_cnt == 8'h00;
	wire [3:0]   be_half    = bus.addr[1] ? 4'hc : 4'h3;                        // [R16]
	wire [3:0]   be_byte    = 4'h1 << bus.addr[1:0];
	wire [3:0]   next_be    = (bus.transfer_width == `WIDTH_WORD) ? 4'hf :
	                          (bus.transfer_width == `WIDTH_HALF) ? be_half : be_byte; // [R19]
	assign bus.bus_cycle_stretch_enable = stretch;                              // [R14]
	assign bus.rdata = mem_rdata;                                               // [R2]
	//////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge arst_n) begin                        // [R13]
		if (!arst_n) begin
			pend        <= 1'b0;
			pend_write  <= 1'b0;
			wait_cnt    <= 8'h00;
			stretch     <= 1'b1;
			mem_start   <= 1'b0;
			mem_write   <= 1'b0;
			mem_addr    <= 32'h0000_0000;
			mem_byte_en <= 4'h0;
			mem_wdata   <= 32'h0000_0000;
		end else begin
			mem_start <= 1'b0;
			if (cyc_end) begin
				if (pend && pend_write) begin
					mem_wdata <= bus.wdata;                                 // [R2]
				end
				pend       <= cyc_commit;                                   // [R10]
				pend_write <= bus.write;
				if (cyc_commit) begin
					mem_start   <= 1'b1;
					mem_write   <= bus.write;
					mem_addr    <= bus.addr;
					mem_byte_en <= next_be;
				end
				if (need_wait) begin
					wait_cnt <= 8'(WAIT_NONSEQ);
					stretch  <= 1'b0;                                       // [R3]
				end
			end else begin
				if (!wait_done) begin
					wait_cnt <= wait_cnt - 8'h01;
				end
				stretch <= (wait_cnt <= 8'h01) && mem_ready;
			end
		end
	end
endmodule

// File: src/core_bus_end.sv
// core bus end: cycle classification, bursts and address-ahead pipeline
// What this block does
// [R1] nonsequential cycle: unrelated address, fresh access
// [R2] address phase leads data by one cycle
// [R3] back-to-back nonsequential; controller stretches if needed
// [R4] burst steps four bytes word, two halfword
// [R5] first sequential may repeat internal-cycle address
// [R6] no byte-width bursts ever
// [R7] burst opens nonsequential or merged, then sequential
// [R8] width, direction, protection fixed within burst
// [R9] internal cycle: address shown, no access
// [R10] merged pair repeats address; access on sequential
// [R11] controller copes with internal then nonsequential
// [R12] coprocessor cycle: data buses, no memory access
// [R13] outputs launched, inputs sampled, rising edge
// [R14] memory side stretches cycles via clock enable
// [R15] cycle completes only when enable high
// [R16] byte address; low bits ignored by width
// [R17] direction high write, low read, fixed
// [R18] width code byte 00 half 01 word 10
// [R19] writable memory has per-byte write enables
// [R20] protection user fetch 00, user data 01, priv fetch 10
// [R21] protection 11 is privileged data access
// [R22] cycle code i 00 c 01 n 10 s 11
// [R23] compressed fetch halfword, else word bursts
`timescale 1ns/1ps
`include "mem_bus_defs.svh"
module core_bus_end (
	input  wire logic                  clk_sys,
	input  wire logic                  arst_n,
	mem_bus_if.core                    bus,
	input  wire logic                  req_valid,
	input  wire mem_bus_pkg::req_kind_t req_kind,
	input  wire logic [31:0]           req_addr,
	input  wire logic                  req_write,
	input  wire logic                  req_fetch,
	input  wire logic                  req_compressed,
	input  wire logic                  req_privileged,
	input  wire logic [1:0]            req_width,
	input  wire logic [7:0]            req_count,
	input  wire logic [31:0]           req_wdata,
	output logic                       req_ready,
	output logic                       beat_valid,
	output logic [31:0]                beat_rdata,
	output logic                       cycle_done
);
	//////////////////////////////////////////////////////////////////////////////
	logic [31:0]             addr;
	logic                    write;
	logic [1:0]              width;
	logic [1:0]              prot;
	mem_bus_pkg::cycle_type_t ctype;
	logic [31:0]             wdata;
	logic [31:0]             wdata_next;
	logic [7:0]              beats_left;
	logic                    data_phase;
	logic                    data_read;
	logic [31:0]             rdata_q;
	wire  cyc_end    = bus.bus_cycle_stretch_enable;                            // [R15] [R14]
	wire  in_burst   = beats_left != 8'h00;
	wire  take_req   = cyc_end && !in_burst && req_valid;
	wire  is_burst   = (req_kind == mem_bus_pkg::req_burst) || (req_kind == mem_bus_pkg::req_merged);
	wire [1:0] burst_width = req_fetch ? (req_compressed ? `WIDTH_HALF : `WIDTH_WORD) : `WIDTH_WORD; // [R23] [R6]
	wire [1:0] single_width = (req_width == 2'h3) ? `WIDTH_WORD : req_width;   // [R18]
	wire [1:0] next_width = is_burst ? burst_width : single_width;
	wire [1:0] next_prot  = {req_privileged, !req_fetch};                      // [R20] [R21]
	wire       next_write = req_write && !req_fetch;                           // [R17]
	wire [31:0] step      = (width == `WIDTH_HALF) ? `INC_HALF : `INC_WORD;     // [R4]
	wire       is_mem_cyc = ctype[1];
	assign bus.addr                   = addr;
	assign bus.write                  = write;
	assign bus.transfer_width         = width;
	assign bus.access_protection_code = prot;
	assign bus.bus_cycle_type         = ctype;
	assign bus.wdata                  = wdata;
	assign req_ready  = cyc_end && !in_burst;
	assign beat_rdata = rdata_q;
	//////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge arst_n) begin                        // [R13]
		if (!arst_n) begin
			addr       <= `ADDR_RESET;
			write      <= 1'b0;
			width      <= `WIDTH_WORD;
			prot       <= `PROT_PRIV_OP;
			ctype      <= mem_bus_pkg::cyc_internal;
			wdata      <= 32'h0000_0000;
			wdata_next <= 32'h0000_0000;
			beats_left <= 8'h00;
			data_phase <= 1'b0;
			data_read  <= 1'b0;
			rdata_q    <= 32'h0000_0000;
			beat_valid <= 1'b0;
			cycle_done <= 1'b0;
		end else begin
			beat_valid <= 1'b0;
			cycle_done <= cyc_end;
			if (cyc_end) begin
				data_phase <= is_mem_cyc || (ctype == mem_bus_pkg::cyc_coproc); // [R2] [R12]
				data_read  <= !write;
				wdata      <= wdata_next;                                   // [R2]
				if (data_phase && data_read) begin
					rdata_q    <= bus.rdata;
					beat_valid <= 1'b1;
				end
				if (in_burst) begin
					if (ctype != mem_bus_pkg::cyc_internal) begin
						addr <= addr + step;                            // [R4] [R8]
					end
					ctype      <= mem_bus_pkg::cyc_seq;                 // [R5] [R7] [R10]
					wdata_next <= req_wdata;
					beats_left <= beats_left - 8'h01;
				end else if (req_valid) begin
					addr  <= req_addr;                                      // [R16] [R9]
					write <= next_write;
					width <= next_width;
					prot  <= next_prot;
					wdata_next <= req_wdata;
					unique case (req_kind)
						mem_bus_pkg::req_single: begin
							ctype      <= mem_bus_pkg::cyc_nonseq;      // [R1] [R3]
							beats_left <= 8'h00;
						end
						mem_bus_pkg::req_burst: begin
							ctype      <= mem_bus_pkg::cyc_nonseq;      // [R7]
							beats_left <= (req_count == 8'h00) ? 8'h00 : req_count - 8'h01;
						end
						mem_bus_pkg::req_merged: begin
							ctype      <= mem_bus_pkg::cyc_internal;    // [R10]
							beats_left <= (req_count == 8'h00) ? 8'h01 : req_count;
						end
						mem_bus_pkg::req_coproc: begin
							ctype      <= mem_bus_pkg::cyc_coproc;      // [R12]
							beats_left <= 8'h00;
						end
						default: begin
							ctype      <= mem_bus_pkg::cyc_internal;    // [R11]
							beats_left <= 8'h00;
						end
					endcase
				end else begin
					ctype <= mem_bus_pkg::cyc_internal;
				end
			end
		end
	end
endmodule

// File: dv/mem_bus_asserts.sv
// concurrent checks on the core memory bus
`timescale 1ns/1ps
`include "mem_bus_defs.svh"
module mem_bus_asserts (
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic [31:0] addr,
	input wire logic        write,
	input wire logic [1:0]  transfer_width,
	input wire logic [1:0]  access_protection_code,
	input wire logic [1:0]  bus_cycle_type,
	input wire logic        bus_cycle_stretch_enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////
	sequence ns_done;
		bus_cycle_stretch_enable && bus_cycle_type[1];
	endsequence
	sequence i_done;
		bus_cycle_stretch_enable && bus_cycle_type == `CYC_INTERNAL;
	endsequence
	sequence seq_of(logic [1:0] w);
		bus_cycle_type == `CYC_SEQ && transfer_width == w;
	endsequence
	////////////////////////////////////////////////////////////
	width_legal_a: assert property (transfer_width != 2'h3)
		else $error("reserved width code driven");
	no_byte_burst_a: assert property (bus_cycle_type == `CYC_SEQ |-> transfer_width != `WIDTH_BYTE)
		else $error("byte width in sequential cycle");
	word_step_a: assert property (ns_done ##1 seq_of(`WIDTH_WORD) |-> addr == $past(addr) + `INC_WORD)
		else $error("word burst step wrong");
	half_step_a: assert property (ns_done ##1 seq_of(`WIDTH_HALF) |-> addr == $past(addr) + `INC_HALF)
		else $error("halfword burst step wrong");
	merged_addr_a: assert property (i_done ##1 bus_cycle_type == `CYC_SEQ |-> addr == $past(addr))
		else $error("merged sequential address differs");
	burst_attr_a: assert property (ns_done ##1 bus_cycle_type == `CYC_SEQ
		|-> $stable({write, transfer_width, access_protection_code}))
		else $error("burst attributes changed");
	stretch_hold_a: assert property (!bus_cycle_stretch_enable
		|=> $stable({addr, write, transfer_width, access_protection_code, bus_cycle_type}))
		else $error("outputs moved while stretched");
	burst_open_a: assert property (bus_cycle_type == `CYC_SEQ |-> $past(bus_cycle_type) != `CYC_COPROC)
		else $error("sequential cycle after coprocessor cycle");
	fetch_read_a: assert property (access_protection_code[0] == 1'b0 |-> !write)
		else $error("opcode fetch marked as write");
	half_fetch_a: assert property (seq_of(`WIDTH_HALF) |-> access_protection_code[0] == 1'b0 && !write)
		else $error("halfword burst not a fetch");
endmodule

// File: dv/tb.sv
// self-checking bench joining both bus ends
`timescale 1ns/1ps
module tb;
	logic                   clk_sys;
	logic                   arst_n;
	logic                   req_valid;
	mem_bus_pkg::req_kind_t req_kind;
	logic [31:0]            req_addr;
	logic                   req_write;
	logic                   req_fetch;
	logic                   req_compressed;
	logic                   req_privileged;
	logic [1:0]             req_width;
	logic [7:0]             req_count;
	logic [31:0]            req_wdata;
	logic                   req_ready;
	logic                   beat_valid;
	logic [31:0]            beat_rdata;
	logic                   cycle_done;
	logic                   mem_ready;
	logic                   mem_start;
	logic                   mem_write;
	logic [31:0]            mem_addr;
	logic [3:0]             mem_byte_en;
	logic [31:0]            mem_wdata;
	logic [31:0]            mem_rdata;
	logic [31:0]            seed;
	logic [31:0]            rnd = 32'h7707;
	logic [36:0]            acc_q[$];
	logic [31:0]            rd_q[$];
	logic [31:0]            wd_q[$];
	logic [36:0]            e;
	logic [31:0]            wd_exp;
	logic                   wd_arm = 1'b0;
	logic                   wd_due = 1'b0;
	logic                   live = 1'b0;
	logic                   done_exp = 1'b0;
	int                     error_cnt;
	int                     compares;
	int                     k;
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] model(input logic [31:0] a);
		return {a[31:2], 2'h0} ^ 32'h5a3c_0ff0;
	endfunction
	function automatic logic [1:0] exp_width(input mem_bus_pkg::req_kind_t kd, input logic f, c, input logic [1:0] w);
		if (kd == mem_bus_pkg::req_burst || kd == mem_bus_pkg::req_merged) return (f && c) ? 2'h1 : 2'h2;
		return (w == 2'h3) ? 2'h2 : w;
	endfunction
	function automatic logic [3:0] exp_be(input logic [1:0] w, input logic [1:0] lo);
		if (w == 2'h2) return 4'hf;
		if (w == 2'h1) return lo[1] ? 4'hc : 4'h3;
		return 4'h1 << lo;
	endfunction
	assign mem_rdata = model(mem_addr);
	////////////////////////////////////////////////////////////
	mem_bus_if mem_bus_if_inst ();
	core_bus_end core_bus_end_inst (.clk_sys(clk_sys), .arst_n(arst_n), .bus(mem_bus_if_inst.core),
		.req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_write(req_write),
		.req_fetch(req_fetch), .req_compressed(req_compressed), .req_privileged(req_privileged),
		.req_width(req_width), .req_count(req_count), .req_wdata(req_wdata), .req_ready(req_ready),
		.beat_valid(beat_valid), .beat_rdata(beat_rdata), .cycle_done(cycle_done));
	mem_ctrl_end #(.WAIT_NONSEQ(1)) mem_ctrl_end_inst (.clk_sys(clk_sys), .arst_n(arst_n),
		.bus(mem_bus_if_inst.mem), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem_start(mem_start),
		.mem_write(mem_write), .mem_addr(mem_addr), .mem_byte_en(mem_byte_en), .mem_wdata(mem_wdata));
	mem_bus_asserts mem_bus_asserts_inst (.clk_sys(clk_sys), .arst_n(arst_n), .addr(mem_bus_if_inst.addr),
		.write(mem_bus_if_inst.write), .transfer_width(mem_bus_if_inst.transfer_width),
		.access_protection_code(mem_bus_if_inst.access_protection_code),
		.bus_cycle_type(mem_bus_if_inst.bus_cycle_type),
		.bus_cycle_stretch_enable(mem_bus_if_inst.bus_cycle_stretch_enable));
	////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic report_and_stop();
		if (error_cnt == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic issue(input mem_bus_pkg::req_kind_t kd, input logic [31:0] a, input logic wr, f, c, p,
		input logic [1:0] w, input logic [7:0] n);
		logic        fx;
		logic        wx;
		int          beats;
		logic [31:0] step;
		logic [31:0] ba;
		@(negedge clk_sys);
		fx = f & (kd != mem_bus_pkg::req_coproc);
		wx = (wr | kd == mem_bus_pkg::req_coproc) & ~fx;
		req_kind = kd;
		req_addr = a;
		req_write = wx;
		req_fetch = fx;
		req_compressed = c;
		req_privileged = p;
		req_width = w;
		req_count = n;
		req_wdata = ~a;
		req_valid = 1'b1;
		#1;
		while (req_ready !== 1'b1) @(posedge clk_sys) #1;
		@(posedge clk_sys);
		beats = kd == mem_bus_pkg::req_single ? 1 : (kd == mem_bus_pkg::req_burst || kd == mem_bus_pkg::req_merged) ? n : 0;
		step = (fx && c) ? 32'h0000_0002 : 32'h0000_0004;
		for (int i = 0; i < beats; i++) begin
			ba = a + step * i;
			acc_q.push_back({exp_be(exp_width(kd, fx, c, w), ba[1:0]), wx, ba});
			if (wx) wd_q.push_back(~a);
			else rd_q.push_back(model(ba));
		end
		#1;
		while (req_ready !== 1'b1) @(posedge clk_sys) #1;
	endtask
	////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		if (live === 1'b1) chk("cycle_done", {31'h0, done_exp}, {31'h0, cycle_done});
		done_exp = mem_bus_if_inst.bus_cycle_stretch_enable;
		live = arst_n;
		if (wd_due) begin
			chk("mem_wdata", wd_exp, mem_wdata);
			wd_due = 1'b0;
		end
		if (mem_start === 1'b1) begin
			e = acc_q.size() > 0 ? acc_q.pop_front() : '1;
			chk("mem_addr", e[31:0], mem_addr);
			chk("mem_write", {31'h0, e[32]}, {31'h0, mem_write});
			chk("mem_byte_en", {28'h0, e[36:33]}, {28'h0, mem_byte_en});
			if (e[32]) begin
				wd_arm = 1'b1;
				wd_exp = wd_q.size() > 0 ? wd_q.pop_front() : 32'h0;
			end
		end
		if (wd_arm && mem_bus_if_inst.bus_cycle_stretch_enable === 1'b1) begin
			wd_arm = 1'b0;
			wd_due = 1'b1;
		end
		if (beat_valid === 1'b1) chk("beat_rdata", rd_q.size() > 0 ? rd_q.pop_front() : 32'h0, beat_rdata);
	end
	always @(negedge clk_sys) begin
		rnd = lfsr(rnd);
		mem_ready <= rnd[5:4] != 2'h0;
	end
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		arst_n = 1'b0;
		req_valid = 1'b0;
		req_kind = mem_bus_pkg::req_idle;
		{req_addr, req_write, req_fetch, req_compressed, req_privileged} = '0;
		{req_width, req_count, req_wdata} = '0;
		{seed, error_cnt, compares} = {32'h7707, 32'h0, 32'h0};
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys) arst_n = 1'b1;
		issue(mem_bus_pkg::req_single, 32'h0000_1000, 1'b0, 1'b0, 1'b0, 1'b1, 2'h2, 8'h1);
		issue(mem_bus_pkg::req_single, 32'h0000_2004, 1'b1, 1'b0, 1'b0, 1'b1, 2'h2, 8'h1);
		issue(mem_bus_pkg::req_idle, 32'h0000_3000, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 8'h1);
		issue(mem_bus_pkg::req_single, 32'h0000_4000, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2, 8'h1);
		issue(mem_bus_pkg::req_merged, 32'h0000_5000, 1'b0, 1'b1, 1'b1, 1'b1, 2'h1, 8'h3);
		issue(mem_bus_pkg::req_burst, 32'h0000_6000, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2, 8'h4);
		issue(mem_bus_pkg::req_coproc, 32'h0000_7000, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2, 8'h1);
		issue(mem_bus_pkg::req_single, 32'h0000_7003, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 8'h1);
		issue(mem_bus_pkg::req_single, 32'h0000_7008, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3, 8'h1);
		for (k = 0; k < 40; k++) begin
			seed = lfsr(seed);
			issue(seed[2:0] > 3'h4 ? mem_bus_pkg::req_single : mem_bus_pkg::req_kind_t'(seed[2:0]),
				{16'h0, seed[31:18], 2'h0}, seed[3], seed[4], seed[5], seed[6], seed[8:7],
				{6'h0, seed[10:9]} + 8'h1);
		end
		@(negedge clk_sys) req_valid = 1'b0;
		repeat (60) @(negedge clk_sys);
		chk("accesses left", 32'h0, acc_q.size());
		chk("reads left", 32'h0, rd_q.size());
		chk("writes left", 32'h0, wd_q.size());
		report_and_stop();
	end
endmodule
